// File: include/pts_pkg.sv
// Package: constants and types shared by the timestamp delay register bank
`default_nettype none
package pts_pkg;

    // Bus geometry
    localparam int PTS_ADDR_W = 12;
    localparam int PTS_DATA_W = 32;
    localparam int PTS_IDX_W  = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] PTS_IDX_EGRESS_INTERVAL    = 10'h0d0;
    localparam logic [9:0] PTS_IDX_EGRESS_FRAC_TRIM   = 10'h0d1;
    localparam logic [9:0] PTS_IDX_EGRESS_WHOLE_TRIM  = 10'h0d2;
    localparam logic [9:0] PTS_IDX_INGRESS_INTERVAL   = 10'h0d3;
    localparam logic [9:0] PTS_IDX_INGRESS_FRAC_TRIM  = 10'h0d4;
    localparam logic [9:0] PTS_IDX_INGRESS_WHOLE_TRIM = 10'h0d5;
    localparam logic [9:0] PTS_IDX_ADJUST_COUNT       = 10'h0d6;
    localparam logic [9:0] PTS_IDX_EGRESS_CORR        = 10'h0d7;
    localparam logic [9:0] PTS_IDX_INGRESS_CORR       = 10'h0d8;

    // Field positions
    localparam int PTS_FRAC_LSB         = 0;
    localparam int PTS_FRAC_W           = 16;
    localparam int PTS_WHOLE_LSB        = 16;
    localparam int PTS_INTERVAL_WHOLE_W = 9;
    localparam int PTS_TRIM_WHOLE_LSB   = 0;
    localparam int PTS_TRIM_WHOLE_W     = 16;
    localparam int PTS_COUNT_W          = 16;
    localparam int PTS_INGRESS_CNT_LSB  = 16;

    // Pipeline stages between timestamp point and the GMII bus
    localparam logic [3:0] PTS_EGRESS_STAGES  = 4'h4;
    localparam logic [3:0] PTS_INGRESS_STAGES = 4'h4;

    // Values after reset
    localparam logic [31:0] PTS_WORD_RST  = 32'h0;
    localparam logic [15:0] PTS_COUNT_RST = 16'h0;

    typedef struct packed {
        logic [8:0]  whole;
        logic [15:0] frac;
    } pts_interval_t;

    typedef struct packed {
        logic [15:0] whole;
        logic [15:0] frac;
    } pts_trim_t;

    typedef struct packed {
        logic [31:0] ns;
        logic [15:0] frac;
    } pts_ts_t;

    // Signed correction, Q18.16 nanoseconds
    typedef logic signed [33:0] pts_corr_t;

    typedef enum logic [1:0] {
        PTS_IDLE   = 2'b00,
        PTS_ANSWER = 2'b01
    } pts_bus_state_t;

endpackage
`default_nettype wire

// File: hw/pts_delay_calc.sv
// Stage-delay and static-trim correction for one direction
`default_nettype none
module pts_delay_calc
    import pts_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire pts_interval_t interval,
    input  wire pts_trim_t     trim,
    input  wire logic [3:0]    stages,
    output var  pts_corr_t     corr
);

    logic [28:0] stage_delay;
    pts_corr_t   next_corr;

    // Period times whole stage count; the period and the product have 16 fraction bits
    assign stage_delay = {4'h0, interval} * {25'h0, stages}; // RQ3

    // Whole and fraction form one signed value; trim may be negative
    assign next_corr = pts_corr_t'($signed({5'h0, stage_delay}))
                     + pts_corr_t'($signed({trim.whole, trim.frac})); // RQ11

    // Registered so the multiplier stays off the timestamp path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            corr <= '0;
        end else begin
            corr <= next_corr;
        end
    end

endmodule // pts_delay_calc
`default_nettype wire

// File: hw/pts_ts_adjust.sv
// Adds the correction to a captured timestamp, one cycle of latency
`default_nettype none
module pts_ts_adjust
    import pts_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      cap_valid,
    input  wire pts_ts_t   cap_ts,
    input  wire pts_corr_t corr,
    output var  logic      out_valid,
    output var  pts_ts_t   out_ts
);

    logic [47:0] next_sum;

    // Seconds field is not kept here, so the nanosecond count wraps
    assign next_sum = {cap_ts.ns, cap_ts.frac} + 48'(corr); // RQ11

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= cap_valid;
        end
    end

    // Timestamp is held between captures
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ts <= '0;
        end else if (cap_valid) begin
            out_ts <= pts_ts_t'(next_sum);
        end
    end

endmodule // pts_ts_adjust
`default_nettype wire

// File: hw/pts_regs.sv
// Timestamp delay register bank: APB slave, corrections and timestamp adjust
//
// Overview of operation
// (RQ1) Egress interval: fraction 0-15, whole 16-24
// (RQ2) Ingress interval uses the same layout
// (RQ3) Correction is period times pipeline stage count
// (RQ4) Egress fraction trim in bits 0-15
// (RQ5) Egress whole trim in bits 0-15
// (RQ6) Ingress fraction trim in bits 0-15
// (RQ7) Ingress whole trim in bits 0-15
// (RQ8) All six registers clear to zero
// (RQ9) Software sets 8 ns at 125 MHz
// (RQ10) Software treats one UI as 800 ps
// (RQ11) Timestamp gets stage delay plus static trim
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module pts_regs
    import pts_pkg::*;
(
    input  wire logic            CLK,
    input  wire logic            RSTN,
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [11:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    input  wire logic [3:0]      PSTRB,
    output var  logic [31:0]     PRDATA,
    output var  logic            PREADY,
    output var  logic            PSLVERR,
    input  wire logic            EGRESS_CAP_VALID,
    input  wire pts_ts_t         EGRESS_CAP_TS,
    input  wire logic            INGRESS_CAP_VALID,
    input  wire pts_ts_t         INGRESS_CAP_TS,
    output var  logic            EGRESS_TS_VALID,
    output var  pts_ts_t         EGRESS_TS,
    output var  logic            INGRESS_TS_VALID,
    output var  pts_ts_t         INGRESS_TS
);

    // Register map, byte address four times the index:
    //   0x340 egress interval   0x34c ingress interval
    //   0x344 egress fraction   0x350 ingress fraction
    //   0x348 egress whole trim 0x354 ingress whole trim
    //   0x358 timestamp counts, read only
    //   0x35c/0x360 corrections, low word, read only
    // Answer comes one cycle after setup, no waits.
    // Whole trims are signed; intervals unsigned.
    // Counters wrap; software takes differences.
    // Reserved bits read zero and are dropped on write.
    // Refused: unmapped words and writes to read-only ones.

    // Byte lanes of a write merged over the current word
    function automatic logic [31:0] pts_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Interval word: fraction low, whole above, top bits read zero
    function automatic logic [31:0] pts_interval_word(input pts_interval_t iv);
        logic [31:0] w;
        w = '0;
        w[PTS_FRAC_LSB +: PTS_FRAC_W] = iv.frac;
        w[PTS_WHOLE_LSB +: PTS_INTERVAL_WHOLE_W] = iv.whole;
        return w;
    endfunction

    // Trim word: one 16-bit field in the low half, upper half zero
    function automatic logic [31:0] pts_trim_word(input logic [15:0] field);
        logic [31:0] w;
        w = '0;
        w[PTS_FRAC_LSB +: PTS_FRAC_W] = field;
        return w;
    endfunction

    // Index match of a byte address
    function automatic logic pts_hit(input logic [11:0] addr, input logic [9:0] idx);
        return addr[PTS_ADDR_W-1:2] == idx;
    endfunction

    // Bus handshake state
    pts_bus_state_t bus_state;
    pts_bus_state_t next_bus_state;

    pts_interval_t  egress_clock_interval;
    pts_trim_t      egress_trim;
    pts_interval_t  ingress_clock_interval;
    pts_trim_t      ingress_trim;

    logic [15:0]    egress_count;
    logic [15:0]    ingress_count;

    pts_corr_t      egress_corr;
    pts_corr_t      ingress_corr;

    logic           setup_phase;
    logic           write_commit;
    logic [31:0]    rd_word;
    logic           rd_mapped;
    logic [31:0]    wr_word;
    logic           wr_mapped;
    logic           egress_done;
    logic           ingress_done;
    logic [31:0]    wr_merged;
    logic [5:0]     wr_en;

    // Setup cycle seen while idle; the answer follows in the access cycle
    assign setup_phase  = PSEL && !PENABLE;
    // A write lands only at the edge where the master sees PREADY
    assign write_commit = PSEL && PENABLE && PWRITE && PREADY && bus_state == PTS_ANSWER;

    // Bus state: one wait-free access per transfer
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            PTS_IDLE: begin
                if (setup_phase) begin
                    next_bus_state = PTS_ANSWER;
                end
            end
            PTS_ANSWER: begin
                next_bus_state = PTS_IDLE;
            end
            default: begin
                next_bus_state = PTS_IDLE;
            end
        endcase
    end

    // State register; reset returns the bus to idle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_state <= PTS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // Read multiplexer; reserved bits and unmapped words read zero
    always_comb begin
        rd_word   = '0;
        rd_mapped = 1'b1;
        if (pts_hit(PADDR, PTS_IDX_EGRESS_INTERVAL)) begin
            rd_word = pts_interval_word(egress_clock_interval); // RQ1
        end else if (pts_hit(PADDR, PTS_IDX_EGRESS_FRAC_TRIM)) begin
            rd_word = pts_trim_word(egress_trim.frac); // RQ4
        end else if (pts_hit(PADDR, PTS_IDX_EGRESS_WHOLE_TRIM)) begin
            rd_word = pts_trim_word(egress_trim.whole); // RQ5
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_INTERVAL)) begin
            rd_word = pts_interval_word(ingress_clock_interval); // RQ2
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_FRAC_TRIM)) begin
            rd_word = pts_trim_word(ingress_trim.frac); // RQ6
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_WHOLE_TRIM)) begin
            rd_word = pts_trim_word(ingress_trim.whole); // RQ7
        end else if (pts_hit(PADDR, PTS_IDX_ADJUST_COUNT)) begin
            rd_word = {ingress_count, egress_count};
        end else if (pts_hit(PADDR, PTS_IDX_EGRESS_CORR)) begin
            rd_word = egress_corr[31:0];
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_CORR)) begin
            rd_word = ingress_corr[31:0];
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // Old word for strobe merging; only writable words are mapped here
    always_comb begin
        wr_word   = '0;
        wr_mapped = 1'b1;
        if (pts_hit(PADDR, PTS_IDX_EGRESS_INTERVAL)) begin
            wr_word = pts_interval_word(egress_clock_interval);
        end else if (pts_hit(PADDR, PTS_IDX_EGRESS_FRAC_TRIM)) begin
            wr_word = pts_trim_word(egress_trim.frac);
        end else if (pts_hit(PADDR, PTS_IDX_EGRESS_WHOLE_TRIM)) begin
            wr_word = pts_trim_word(egress_trim.whole);
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_INTERVAL)) begin
            wr_word = pts_interval_word(ingress_clock_interval);
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_FRAC_TRIM)) begin
            wr_word = pts_trim_word(ingress_trim.frac);
        end else if (pts_hit(PADDR, PTS_IDX_INGRESS_WHOLE_TRIM)) begin
            wr_word = pts_trim_word(ingress_trim.whole);
        end else begin
            wr_mapped = 1'b0;
        end
    end

    // Ready for exactly the access cycle of each transfer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= bus_state == PTS_IDLE && setup_phase;
        end
    end

    // Read data sampled in the setup cycle, held through the access cycle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= PTS_WORD_RST;
        end else if (bus_state == PTS_IDLE && setup_phase) begin
            PRDATA <= PWRITE ? PTS_WORD_RST : rd_word;
        end
    end

    // Unmapped reads and writes, and writes to read-only words, flag an error
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PSLVERR <= 1'b0;
        end else if (bus_state == PTS_IDLE && setup_phase) begin
            PSLVERR <= PWRITE ? !wr_mapped : !rd_mapped;
        end else begin
            PSLVERR <= 1'b0;
        end
    end

    // Write data merged over the old word once, shared by every writable word
    assign wr_merged = pts_merge(wr_word, PWDATA, PSTRB);

    // One write enable per writable word, in register order; at most one is high
    assign wr_en = {6{write_commit}} & {pts_hit(PADDR, PTS_IDX_INGRESS_WHOLE_TRIM),
                                        pts_hit(PADDR, PTS_IDX_INGRESS_FRAC_TRIM),
                                        pts_hit(PADDR, PTS_IDX_INGRESS_INTERVAL),
                                        pts_hit(PADDR, PTS_IDX_EGRESS_WHOLE_TRIM),
                                        pts_hit(PADDR, PTS_IDX_EGRESS_FRAC_TRIM),
                                        pts_hit(PADDR, PTS_IDX_EGRESS_INTERVAL)};

    // Egress clock interval; bits 25 to 31 are dropped on write
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            egress_clock_interval <= pts_interval_t'(PTS_WORD_RST[24:0]); // RQ8
        end else if (wr_en[0]) begin
            egress_clock_interval <= pts_interval_t'(wr_merged[24:0]); // RQ1
        end
    end

    // Ingress clock interval; same layout as egress
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ingress_clock_interval <= pts_interval_t'(PTS_WORD_RST[24:0]); // RQ8
        end else if (wr_en[3]) begin
            ingress_clock_interval <= pts_interval_t'(wr_merged[24:0]); // RQ2
        end
    end

    // Egress static trim, fraction and whole in separate words
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            egress_trim <= pts_trim_t'(PTS_WORD_RST); // RQ8
        end else if (wr_en[1]) begin
            egress_trim.frac <= wr_merged[PTS_FRAC_LSB +: PTS_FRAC_W]; // RQ4
        end else if (wr_en[2]) begin
            egress_trim.whole <= wr_merged[PTS_TRIM_WHOLE_LSB +: PTS_TRIM_WHOLE_W]; // RQ5
        end
    end

    // Ingress static trim; whole part is two's complement for negative trims
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ingress_trim <= pts_trim_t'(PTS_WORD_RST); // RQ8
        end else if (wr_en[4]) begin
            ingress_trim.frac <= wr_merged[PTS_FRAC_LSB +: PTS_FRAC_W]; // RQ6
        end else if (wr_en[5]) begin
            ingress_trim.whole <= wr_merged[PTS_TRIM_WHOLE_LSB +: PTS_TRIM_WHOLE_W]; // RQ7
        end
    end

    // Per-direction correction: interval times stages plus trim
    pts_delay_calc u_egress_calc (
        .clk      (CLK),
        .rst_n    (RSTN),
        .interval (egress_clock_interval),
        .trim     (egress_trim),
        .stages   (PTS_EGRESS_STAGES),
        .corr     (egress_corr)
    ); // RQ3

    // Receive direction uses its own stage count
    pts_delay_calc u_ingress_calc (
        .clk      (CLK),
        .rst_n    (RSTN),
        .interval (ingress_clock_interval),
        .trim     (ingress_trim),
        .stages   (PTS_INGRESS_STAGES),
        .corr     (ingress_corr)
    ); // RQ3

    // Captured timestamps corrected for the matching direction
    pts_ts_adjust u_egress_adjust (
        .clk       (CLK),
        .rst_n     (RSTN),
        .cap_valid (EGRESS_CAP_VALID),
        .cap_ts    (EGRESS_CAP_TS),
        .corr      (egress_corr),
        .out_valid (egress_done),
        .out_ts    (EGRESS_TS)
    ); // RQ11

    // Receive timestamps take the receive correction only
    pts_ts_adjust u_ingress_adjust (
        .clk       (CLK),
        .rst_n     (RSTN),
        .cap_valid (INGRESS_CAP_VALID),
        .cap_ts    (INGRESS_CAP_TS),
        .corr      (ingress_corr),
        .out_valid (ingress_done),
        .out_ts    (INGRESS_TS)
    ); // RQ11

    // Valid pulses come straight from the adjust stage flops
    assign EGRESS_TS_VALID  = egress_done;
    assign INGRESS_TS_VALID = ingress_done;

    // Adjusted timestamp counters; wrap silently so software takes differences
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            egress_count <= PTS_COUNT_RST;
        end else if (egress_done) begin
            egress_count <= egress_count + 16'h1;
        end
    end

    // Ingress count lives in the upper half of the count word
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ingress_count <= PTS_COUNT_RST;
        end else if (ingress_done) begin
            ingress_count <= ingress_count + 16'h1;
        end
    end

endmodule // pts_regs
`default_nettype wire

// File: tb/pts_regs_monitor.sv
// Port checker for the timestamp delay register bank
`default_nettype none
module pts_regs_monitor
    import pts_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        EGRESS_CAP_VALID,
    input wire pts_ts_t     EGRESS_CAP_TS,
    input wire logic        INGRESS_CAP_VALID,
    input wire pts_ts_t     INGRESS_CAP_TS,
    input wire logic        EGRESS_TS_VALID,
    input wire pts_ts_t     EGRESS_TS,
    input wire logic        INGRESS_TS_VALID,
    input wire pts_ts_t     INGRESS_TS
);
    logic [9:0] idx;
    logic       rd_done;

    // Address stays put through the access phase, so it still names the register
    assign idx     = PADDR[11:2];
    assign rd_done = PREADY && !PWRITE && !PSLVERR;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Bus handshake: one wait-free answer per setup cycle
    setup_answered_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("Setup cycle not answered in the next cycle");
    ready_single_a: assert property (PREADY |=> !PREADY)
        else $error("Ready held longer than one cycle");
    no_stray_ready_a: assert property (!PSEL || PENABLE |=> !PREADY)
        else $error("Ready without a preceding setup cycle");
    err_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("Error flag outside an answer");
    // Unused bits read as zero: all of them for intervals and fraction trims, bits 23:16 for whole trims
    egr_interval_bits_a: assert property (rd_done && idx == PTS_IDX_EGRESS_INTERVAL |-> PRDATA[31:25] == 7'h0)
        else $error("Egress interval upper bits not zero");
    igr_interval_bits_a: assert property (rd_done && idx == PTS_IDX_INGRESS_INTERVAL |-> PRDATA[31:25] == 7'h0)
        else $error("Ingress interval upper bits not zero");
    egr_frac_bits_a: assert property (rd_done && idx == PTS_IDX_EGRESS_FRAC_TRIM |-> PRDATA[31:16] == 16'h0)
        else $error("Egress fraction trim upper bits not zero");
    egr_whole_bits_a: assert property (rd_done && idx == PTS_IDX_EGRESS_WHOLE_TRIM |-> PRDATA[23:16] == 8'h0)
        else $error("Egress whole trim unused bits not zero");
    igr_frac_bits_a: assert property (rd_done && idx == PTS_IDX_INGRESS_FRAC_TRIM |-> PRDATA[31:16] == 16'h0)
        else $error("Ingress fraction trim upper bits not zero");
    igr_whole_bits_a: assert property (rd_done && idx == PTS_IDX_INGRESS_WHOLE_TRIM |-> PRDATA[23:16] == 8'h0)
        else $error("Ingress whole trim unused bits not zero");
    reset_quiet_a: assert property (!$past(RSTN) |-> PRDATA == 32'h0 && !PREADY && !EGRESS_TS_VALID)
        else $error("Outputs not cleared by reset");
    // Corrected timestamp follows each capture by exactly one cycle
    egr_ts_turn_a: assert property (EGRESS_CAP_VALID |=> EGRESS_TS_VALID)
        else $error("Egress corrected timestamp late");
    igr_ts_turn_a: assert property (INGRESS_CAP_VALID |=> INGRESS_TS_VALID)
        else $error("Ingress corrected timestamp late");
    egr_ts_hold_a: assert property (!EGRESS_TS_VALID |-> $stable(EGRESS_TS))
        else $error("Egress timestamp changed without a capture");
    igr_ts_hold_a: assert property (!INGRESS_TS_VALID |-> $stable(INGRESS_TS))
        else $error("Ingress timestamp changed without a capture");

    cover property (PREADY && PWRITE && !PSLVERR);
    cover property (PREADY && PSLVERR);
    cover property (EGRESS_TS_VALID && INGRESS_TS_VALID);
endmodule // pts_regs_monitor

bind pts_regs pts_regs_monitor mon (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .EGRESS_CAP_VALID, .EGRESS_CAP_TS, .INGRESS_CAP_VALID, .INGRESS_CAP_TS,
    .EGRESS_TS_VALID, .EGRESS_TS, .INGRESS_TS_VALID, .INGRESS_TS);
`default_nettype wire

// File: tb/pts_regs_bench.sv
// Self-checking bench for the timestamp delay register bank
`default_nettype none
module pts_regs_bench
    import pts_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0]  PSTRB = 4'h0;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, EGRESS_TS_VALID, INGRESS_TS_VALID;
    logic        EGRESS_CAP_VALID = 0, INGRESS_CAP_VALID = 0;
    pts_ts_t     EGRESS_CAP_TS = 48'h0, INGRESS_CAP_TS = 48'h0, EGRESS_TS, INGRESS_TS;
    int          miscompares = 0, checks_done = 0;
    logic [31:0] seed = 32'h21a8;
    logic [31:0] cnt = 32'h0;
    logic [31:0] model [6];
    logic [32:0] bq [$];
    logic [47:0] eq [$], iq [$];

    always #5 CLK = ~CLK;

    pts_regs uut (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
        .EGRESS_CAP_VALID, .EGRESS_CAP_TS, .INGRESS_CAP_VALID, .INGRESS_CAP_TS,
        .EGRESS_TS_VALID, .EGRESS_TS, .INGRESS_TS_VALID, .INGRESS_TS);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Writable bits of each register
    function automatic logic [31:0] fmask(input logic [9:0] i);
        return (i == 10'h0d0 || i == 10'h0d3) ? 32'h01ffffff : 32'h0000ffff;
    endfunction

    // Period times stages plus signed trim, all in nanosecond fixed point with 16 fraction bits
    function automatic logic [47:0] corr(input int d, input logic [3:0] st);
        return 48'(model[3*d][24:0]) * 48'(st) + {{16{model[3*d+2][15]}}, model[3*d+2][15:0], model[3*d+1][15:0]};
    endfunction

    task automatic cmp_bus(input logic [32:0] e, input logic [32:0] s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("Error bus answer expected %h seen %h", e, s);
        end
    endtask

    task automatic cmp_ts(input string n, input logic [47:0] e, input logic [47:0] s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One APB transfer; the note of the expected answer is queued first
    task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
        int          n;
        logic        ok;
        logic [31:0] m;
        n = 0;
        ok = i >= 10'h0d0 && i <= 10'h0d5;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (!w && i == 10'h0d6) begin
            bq.push_back({1'b0, cnt});
        end else if (!ok) begin
            bq.push_back({1'b1, 32'h0});
        end else if (w) begin
            model[i - 10'h0d0] = ((model[i - 10'h0d0] & ~m) | (d & m)) & fmask(i);
            bq.push_back(33'h0);
        end else begin
            bq.push_back({1'b0, model[i - 10'h0d0]});
        end
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= {i, 2'b00};
        PWDATA <= d;
        PSTRB <= s;
        @(posedge CLK);
        PENABLE <= 1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            report_and_stop();
        end
        // Release with one idle cycle so no strobe is driven twice in a time step
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge CLK);
    endtask

    task automatic do_reset();
        RSTN <= 0;
        repeat (6) @(posedge CLK);
        RSTN <= 1;
        model = '{default: 32'h0};
        cnt = 32'h0;
    endtask

    // Answers are checked where they appear, against the oldest note
    always @(posedge CLK) begin
        if (RSTN === 1'b1 && PREADY === 1'b1) cmp_bus(bq.size() ? bq.pop_front() : 33'hx, {PSLVERR, PRDATA});
        if (EGRESS_TS_VALID === 1'b1) cmp_ts("egress_ts", eq.size() ? eq.pop_front() : 48'hx, EGRESS_TS);
        if (INGRESS_TS_VALID === 1'b1) cmp_ts("ingress_ts", iq.size() ? iq.pop_front() : 48'hx, INGRESS_TS);
    end

    // A hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        report_and_stop();
    end

    initial begin
        logic [31:0]    r;
        logic [47:0]    t;
        logic [9:0]     bad [3];
        bad = '{10'h0cf, 10'h0d7, 10'h0d9};
        do_reset();
        for (int i = 0; i < 7; i++) apb(0, 10'h0d0 + 10'(i), 32'h0, 4'h0);
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            apb(1, 10'h0d0 + 10'(i), 32'hffffffff, 4'hf);
            apb(0, 10'h0d0 + 10'(i), 32'h0, 4'h0);
        end
        apb(1, 10'h0d1, 32'h00000012, 4'h1);
        apb(0, 10'h0d1, 32'h0, 4'h0);
        $display("Test field widths done");
        repeat (30) begin
            r = rnd();
            apb(r[3], 10'h0d0 + 10'(r[6:4] % 6), rnd(), r[11:8]);
        end
        $display("Test random access done");
        // Refused accesses must leave every register untouched
        foreach (bad[k]) apb(1, bad[k], rnd(), 4'hf);
        apb(0, 10'h0cf, 32'h0, 4'h0);
        apb(0, 10'h0d9, 32'h0, 4'h0);
        for (int i = 0; i < 6; i++) apb(0, 10'h0d0 + 10'(i), 32'h0, 4'h0);
        $display("Test refused access done");
        apb(1, 10'h0d0, 32'h00080000, 4'hf);
        apb(1, 10'h0d1, 32'h00008000, 4'hf);
        apb(1, 10'h0d2, 32'h0000fffe, 4'hf);
        apb(1, 10'h0d3, rnd(), 4'hf);
        // A 26 UI delay at 0.8 ns per UI is 20.8 ns: whole 20, fraction 0.8
        apb(1, 10'h0d4, 32'h0000cccc, 4'hf);
        apb(1, 10'h0d5, 32'h00000014, 4'hf);
        repeat (3) @(posedge CLK);
        repeat (40) begin
            r = rnd();
            t = {rnd(), r[31:16]};
            EGRESS_CAP_VALID <= r[0];
            INGRESS_CAP_VALID <= r[1];
            EGRESS_CAP_TS <= t;
            INGRESS_CAP_TS <= ~t;
            if (r[0]) eq.push_back(t + corr(0, PTS_EGRESS_STAGES));
            if (r[1]) iq.push_back(~t + corr(1, PTS_INGRESS_STAGES));
            cnt += {15'h0, r[1], 15'h0, r[0]};
            @(posedge CLK);
        end
        EGRESS_CAP_VALID <= 0;
        INGRESS_CAP_VALID <= 0;
        repeat (4) @(posedge CLK);
        apb(0, 10'h0d6, 32'h0, 4'h0);
        $display("Test timestamp correction done");
        do_reset();
        for (int i = 0; i < 7; i++) apb(0, 10'h0d0 + 10'(i), 32'h0, 4'h0);
        $display("Test second reset done");
        if (bq.size() + eq.size() + iq.size() != 0) miscompares++;
        report_and_stop();
    end
endmodule // pts_regs_bench
`default_nettype wire
